/* File: debug_port_defs.svh */
// Constants for the debug port front end: selection patterns, counts,
// instruction codes, access-port numbers and synchroniser reset values.
// Assumes inclusion by bare name from every file that needs them.
// Contract
// [R01] After external reset release, first debug clock fall marks a debugger.
// [R02] A detected debugger forces the debug pins to the debug function.
// [R03] Attachment never halts the core; only the probe halts it later.
// [R04] Debug clock low at external reset release raises a core reset request.
// [R05] The core reset request stays until the manager port withdraws it.
// [R06] Every reset leaves the combined port in scan mode, serial wire off; the code clears swd_mode on device reset only, not on external reset.
// [R07] Over 50 highs, 0x79E7 MSB first, over 50 highs: go serial wire.
// [R08] Over 50 highs, 0x3CE7 MSB first, over 50 highs: back to scan mode.
// [R09] Serial wire mode releases TDI and lets TDO carry trace output.
// [R10] In serial wire mode the boundary-scan TAP is unavailable.
// [R11] In scan mode both TAPs run together and capture every instruction.
// [R12] TDO comes from the boundary-scan TAP for its instructions, else port.
// [R13] Access-port select 0 is system bus port, 1 is system manager port.
// [R14] Codes 0000 and 0001 are EXTEST and SAMPLE_PRELOAD on the scan chain.
// [R15] Code 0100 is INTEST, testing internal logic through the chain.
// [R16] Code 0101 is CLAMP: bypass register, outputs from the chain.
// [R17] Codes 1000, 1010, 1011 are ABORT, DPACC, APACC; 1100, 1101 reserved.
// [R18] Code 1110 is IDCODE and 1111 is BYPASS through a one-bit register.
// [R19] The front end is held in reset while the TAP sits in Test-Logic-Reset.
// [R20] The probe holds TMS high five clocks after detection before using it.
// [R21] Debugger detection persists until the next device reset.
// [R22] Reserved codes are not claimed by the boundary-scan TAP.
`ifndef DEBUG_PORT_DEFS_SVH
`define DEBUG_PORT_DEFS_SVH

`define SEL_TO_SWD      16'h79E7
`define SEL_TO_JTAG     16'h3CE7
`define SEL_MIN_HIGH    6'h33
`define SEL_PAT_LAST    4'hF

`define IR_EXTEST       4'h0
`define IR_SAMPLE       4'h1
`define IR_INTEST       4'h4
`define IR_CLAMP        4'h5
`define IR_ABORT        4'h8
`define IR_DPACC        4'hA
`define IR_APACC        4'hB
`define IR_RSVD_A       4'hC
`define IR_RSVD_B       4'hD
`define IR_IDCODE       4'hE
`define IR_BYPASS       4'hF
`define IR_CAPTURE_VAL  4'h1

`define AP_SYSTEM_BUS   8'h00
`define AP_SYS_MANAGER  8'h01

`define SYNC_RST_VAL    4'h1

`endif

/* File: debug_port_pkg.sv */
// Types shared by the debug port front end modules.
// Assumes debug_port_defs.svh for the numeric constants.
package debug_port_pkg;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001, TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR  = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400, TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR  = 16'h2000,
    TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    SEL_HUNT = 3'h1,
    SEL_PAT  = 3'h2,
    SEL_TAIL = 3'h4
  } sel_state_t;

  typedef struct packed {
    logic select;
    logic extest;
    logic sample;
    logic intest;
    logic clamp;
    logic capture;
    logic shift;
    logic update;
  } bscan_ctl_t;

  typedef struct packed {
    logic abort;
    logic dpacc;
    logic apacc;
    logic idcode;
    logic bypass;
    logic reserved;
  } dp_instr_t;

endpackage : debug_port_pkg

/* File: pin_sync.sv */
// Three-stage synchroniser for the debug pins.
// Assumes asynchronous pin levels; a change counts once stages two and
// three agree.
`timescale 1ns/1ps
`include "debug_port_defs.svh"
module pin_sync (
  input  wire logic       clk,    // System clock
  input  wire logic       rst_n,  // Synchronised reset, active low
  input  wire logic [3:0] din,    // Raw pin levels
  output logic      [3:0] dout    // Filtered levels
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] next_dout;

  always_comb begin
    next_dout = ((s2 ~^ s3) & s2) | (~(s2 ~^ s3) & dout);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1   <= `SYNC_RST_VAL;
      s2   <= `SYNC_RST_VAL;
      s3   <= `SYNC_RST_VAL;
      dout <= `SYNC_RST_VAL;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule : pin_sync

/* File: tap_fsm.sv */
// Scan TAP state machine with the shared instruction register.
// Assumes debug clock edges already detected in the system clock domain.
`timescale 1ns/1ps
`include "debug_port_defs.svh"
module tap_fsm (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Synchronised reset, active low
  input  wire logic       enable,    // Scan mode with debugger attached
  input  wire logic       tck_rise,  // Debug clock rising edge
  input  wire logic       tck_fall,  // Debug clock falling edge
  input  wire logic       tms,       // Mode line level
  input  wire logic       tdi,       // Data in level
  output debug_port_pkg::tap_state_t state,  // TAP state
  output logic      [3:0] ir,        // Held instruction
  output logic            ir_lsb     // Instruction shifter output bit
);
  import debug_port_pkg::*;

  tap_state_t next_state;
  logic [3:0] ir_sh;
  logic [3:0] next_ir_sh;
  logic [3:0] next_ir;

  function automatic tap_state_t tap_step(tap_state_t s, logic m);
    case (s)
      TAP_RESET:  tap_step = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_step = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_step = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_step = TAP_RESET;
    endcase
  endfunction : tap_step

  always_comb begin
    next_state = state;
    next_ir_sh = ir_sh;
    next_ir    = ir;
    if (!enable) begin
      next_state = TAP_RESET;                                     // [R10]
      next_ir    = `IR_IDCODE;
    end else begin
      if (tck_rise) begin
        next_state = tap_step(state, tms);                        // [R20]
        if (state == TAP_CAP_IR)
          next_ir_sh = `IR_CAPTURE_VAL;
        else if (state == TAP_SH_IR)
          next_ir_sh = {tdi, ir_sh[3:1]};
      end
      if (tck_fall && state == TAP_UPD_IR)
        next_ir = ir_sh;                                          // [R11]
      if (state == TAP_RESET)
        next_ir = `IR_IDCODE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TAP_RESET;
      ir_sh <= 4'h0;
      ir    <= `IR_IDCODE;
    end else begin
      state <= next_state;
      ir_sh <= next_ir_sh;
      ir    <= next_ir;
    end
  end

  assign ir_lsb = ir_sh[0];
endmodule : tap_fsm

/* File: debug_port_hotplug_select.sv */
// Debug port front end: hot-plug detection, core reset request, scan and
// serial-wire selection, boundary-scan decode and TDO steering.
// Assumes the probe drives the pins asynchronously; the debug port core,
// trace unit and boundary-scan chain run on clk.
`timescale 1ns/1ps
`include "debug_port_defs.svh"
module debug_port_hotplug_select (
  input  wire logic       clk,            // System clock, 200 MHz
  input  wire logic       rst_b,          // Device reset, active low
  input  wire logic       tck_pin,        // debug_clock_line pin
  input  wire logic       mode_data_line, // TMS / serial data pin level
  input  wire logic       tdi_pin,        // Test data in pin
  input  wire logic       ext_reset_b,    // External reset pin
  input  wire logic       dp_tdo,         // scan_debug_port serial out
  input  wire logic       bsr_so,         // Boundary chain serial out
  input  wire logic       async_trace_out,// Trace unit serial stream
  input  wire logic       system_manager_access_port_clear,     // Manager port withdraws request
  input  wire logic [7:0] access_port_select, // Selected port number
  output logic            debug_pins_claimed, // Pins given to debug
  output logic            core_reset_req, // Core reset request
  output logic            swd_mode,       // Serial wire mode active
  output logic            tdi_released,   // TDI free for other use
  output logic            tdo_out,        // TDO pin output level
  output logic            tdo_oe_b,       // TDO enable, low drives
  output logic            front_end_reset,// Front end sync reset
  output logic      [3:0] ir_value,       // Instruction held by TAPs
  output debug_port_pkg::bscan_ctl_t bscan, // Boundary chain control
  output debug_port_pkg::dp_instr_t  dp_instr, // Port instruction decode
  output logic            sel_bus_ap,     // system_bus_access_port chosen
  output logic            sel_mgr_ap      // Manager port chosen
);
  import debug_port_pkg::*;

  // Reset release
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // Pin synchronisation and edge detection
  logic [3:0] pins;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       xrst_s;
  logic       tck_q;
  logic       xrst_q;
  logic       tck_rise;
  logic       tck_fall;
  logic       xrst_rise;

  pin_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({ext_reset_b, tdi_pin, mode_data_line, tck_pin}),
    .dout  (pins)
  );

  assign tck_s  = pins[0];
  assign tms_s  = pins[1];
  assign tdi_s  = pins[2];
  assign xrst_s = pins[3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_q  <= 1'b1;
      xrst_q <= 1'b0;
    end else begin
      tck_q  <= tck_s;
      xrst_q <= xrst_s;
    end
  end

  assign tck_rise  = tck_s & ~tck_q;
  assign tck_fall  = ~tck_s & tck_q;
  assign xrst_rise = xrst_s & ~xrst_q;

  // Hot-plug detection and core reset request
  logic next_attached;
  logic next_core_req;

  always_comb begin
    next_attached = debug_pins_claimed;
    if (xrst_s && tck_fall)
      next_attached = 1'b1;                                       // [R01]
    // Set wins over the manager port's clear
    next_core_req = core_reset_req & ~system_manager_access_port_clear;                 // [R05]
    if (xrst_rise && !tck_s)
      next_core_req = 1'b1;                                       // [R04]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_pins_claimed <= 1'b0;
      core_reset_req     <= 1'b0;
    end else begin
      debug_pins_claimed <= next_attached;                        // [R21]
      core_reset_req     <= next_core_req;                        // [R03]
    end
  end

  // Scan / serial-wire selection sequence detector
  sel_state_t sel;
  sel_state_t next_sel;
  logic [5:0]  run;
  logic [5:0]  next_run;
  logic [15:0] pat;
  logic [15:0] next_pat;
  logic [3:0]  bits;
  logic [3:0]  next_bits;
  logic        next_swd;
  logic [15:0] want;

  assign want = swd_mode ? `SEL_TO_JTAG : `SEL_TO_SWD;

  always_comb begin
    next_sel  = sel;
    next_run  = run;
    next_pat  = pat;
    next_bits = bits;
    next_swd  = swd_mode;
    if (tck_rise) begin
      case (sel)
        SEL_HUNT: begin
          if (tms_s) begin
            if (run < `SEL_MIN_HIGH)
              next_run = run + 6'h01;
          end else if (run >= `SEL_MIN_HIGH) begin
            next_sel  = SEL_PAT;
            next_pat  = 16'h0000;
            next_bits = 4'h1;
            next_run  = 6'h00;
          end else begin
            next_run = 6'h00;
          end
        end
        SEL_PAT: begin
          next_pat  = {pat[14:0], tms_s};
          next_bits = bits + 4'h1;
          if (bits == `SEL_PAT_LAST) begin
            next_run = 6'h00;
            if ({pat[14:0], tms_s} == want)
              next_sel = SEL_TAIL;                                // [R07]
            else
              next_sel = SEL_HUNT;
          end
        end
        SEL_TAIL: begin
          if (!tms_s) begin
            next_sel = SEL_HUNT;
            next_run = 6'h00;
          end else if (run + 6'h01 >= `SEL_MIN_HIGH) begin
            next_swd = ~swd_mode;                                 // [R08]
            next_sel = SEL_HUNT;
            next_run = `SEL_MIN_HIGH;
          end else begin
            next_run = run + 6'h01;
          end
        end
        default: begin
          next_sel = SEL_HUNT;
          next_run = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel      <= SEL_HUNT;
      run      <= 6'h00;
      pat      <= 16'h0000;
      bits     <= 4'h0;
      swd_mode <= 1'b0;                                           // [R06]
    end else begin
      sel      <= next_sel;
      run      <= next_run;
      pat      <= next_pat;
      bits     <= next_bits;
      swd_mode <= next_swd;
    end
  end

  // TAP shared by both instruction decoders
  tap_state_t tap_state;
  logic [3:0] ir;
  logic       ir_lsb;
  logic       tap_en;

  assign tap_en = debug_pins_claimed & ~swd_mode;                 // [R10]

  tap_fsm u_tap (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (tap_en),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall),
    .tms      (tms_s),
    .tdi      (tdi_s),
    .state    (tap_state),
    .ir       (ir),
    .ir_lsb   (ir_lsb)
  );

  function automatic logic bscan_hit(logic [3:0] code);
    // Reserved codes fall through to the debug port
    bscan_hit = (code == `IR_EXTEST) || (code == `IR_SAMPLE) ||
                (code == `IR_INTEST) || (code == `IR_CLAMP);      // [R22]
  endfunction : bscan_hit

  // Boundary-scan control, decode and bypass register
  bscan_ctl_t next_bscan;
  dp_instr_t  next_dp;
  logic       bypass_bit;
  logic       next_bypass;
  logic       hit;

  assign hit = tap_en & bscan_hit(ir);

  always_comb begin
    next_bscan         = '0;
    next_bscan.select  = hit && (ir != `IR_CLAMP);                // [R14]
    next_bscan.extest  = tap_en && (ir == `IR_EXTEST);            // [R14]
    next_bscan.sample  = tap_en && (ir == `IR_SAMPLE);            // [R14]
    next_bscan.intest  = tap_en && (ir == `IR_INTEST);            // [R15]
    next_bscan.clamp   = tap_en && (ir == `IR_CLAMP);             // [R16]
    next_bscan.capture = next_bscan.select && tck_rise &&
                         (tap_state == TAP_CAP_DR);
    next_bscan.shift   = next_bscan.select && tck_rise &&
                         (tap_state == TAP_SH_DR);
    next_bscan.update  = next_bscan.select && tck_fall &&
                         (tap_state == TAP_UPD_DR);
    next_dp          = '0;
    next_dp.abort    = tap_en && (ir == `IR_ABORT);               // [R17]
    next_dp.dpacc    = tap_en && (ir == `IR_DPACC);               // [R17]
    next_dp.apacc    = tap_en && (ir == `IR_APACC);               // [R17]
    next_dp.reserved = tap_en &&
                       ((ir == `IR_RSVD_A) || (ir == `IR_RSVD_B)); // [R17]
    next_dp.idcode   = tap_en && (ir == `IR_IDCODE);              // [R18]
    next_dp.bypass   = tap_en && (ir == `IR_BYPASS);              // [R18]
    next_bypass = bypass_bit;
    if (tck_rise && tap_state == TAP_CAP_DR)
      next_bypass = 1'b0;
    else if (tck_rise && tap_state == TAP_SH_DR)
      next_bypass = tdi_s;                                        // [R18]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bscan      <= '0;
      dp_instr   <= '0;
      bypass_bit <= 1'b0;
    end else begin
      bscan      <= next_bscan;
      dp_instr   <= next_dp;
      bypass_bit <= next_bypass;
    end
  end

  // TDO steering, changed on the debug clock's falling edge in scan mode
  logic next_tdo;
  logic next_tdo_oe_b;

  always_comb begin
    next_tdo      = tdo_out;
    next_tdo_oe_b = tdo_oe_b;
    if (!debug_pins_claimed) begin
      next_tdo      = 1'b0;
      next_tdo_oe_b = 1'b1;
    end else if (swd_mode) begin
      next_tdo      = async_trace_out;                            // [R09]
      next_tdo_oe_b = 1'b0;
    end else if (tck_fall) begin
      next_tdo_oe_b = 1'b1;
      if (tap_state == TAP_SH_IR) begin
        next_tdo      = hit ? ir_lsb : dp_tdo;                    // [R12]
        next_tdo_oe_b = 1'b0;
      end else if (tap_state == TAP_SH_DR) begin
        if (!hit)
          next_tdo = dp_tdo;                                      // [R12]
        else if (ir == `IR_CLAMP)
          next_tdo = bypass_bit;                                  // [R16]
        else
          next_tdo = bsr_so;
        next_tdo_oe_b = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out  <= 1'b0;
      tdo_oe_b <= 1'b1;
    end else begin
      tdo_out  <= next_tdo;
      tdo_oe_b <= next_tdo_oe_b;
    end
  end

  // Remaining registered outputs
  logic next_fe_reset;
  logic next_tdi_rel;
  logic next_bus_ap;
  logic next_mgr_ap;

  always_comb begin
    next_fe_reset = ~tap_en | (tap_state == TAP_RESET);           // [R19]
    next_tdi_rel  = ~debug_pins_claimed | swd_mode;               // [R02]
    next_bus_ap   = (access_port_select == `AP_SYSTEM_BUS);       // [R13]
    next_mgr_ap   = (access_port_select == `AP_SYS_MANAGER);      // [R13]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      front_end_reset <= 1'b1;
      tdi_released    <= 1'b1;
      sel_bus_ap      <= 1'b0;
      sel_mgr_ap      <= 1'b0;
      ir_value        <= `IR_IDCODE;
    end else begin
      front_end_reset <= next_fe_reset;
      tdi_released    <= next_tdi_rel;                            // [R09]
      sel_bus_ap      <= next_bus_ap;
      sel_mgr_ap      <= next_mgr_ap;
      ir_value        <= ir;                                      // [R11]
    end
  end

endmodule : debug_port_hotplug_select

/* File: debug_port_hotplug_select_monitor.sv */
// Assertion checker watching the ports of the debug port front end.
// Assumes a single clk domain and a bind onto debug_port_hotplug_select.
`timescale 1ns/1ps
module debug_port_hotplug_select_monitor
  import debug_port_pkg::*;
(
  input wire logic       clk,                // System clock
  input wire logic       rst_b,              // Device reset, active low
  input wire logic       tck_pin,            // Debug clock pin
  input wire logic       system_manager_access_port_clear,         // Request withdrawal
  input wire logic [7:0] access_port_select, // Selected port number
  input wire logic       async_trace_out,    // Trace stream
  input wire logic       debug_pins_claimed, // Debugger detected
  input wire logic       core_reset_req,     // Core reset request
  input wire logic       swd_mode,           // Serial wire mode
  input wire logic       tdi_released,       // TDI free
  input wire logic       tdo_out,            // TDO level
  input wire logic       tdo_oe_b,           // TDO enable, low drives
  input wire logic       front_end_reset,    // Front end reset
  input wire logic [3:0] ir_value,           // Held instruction
  input bscan_ctl_t      bscan,              // Boundary chain control
  input dp_instr_t       dp_instr,           // Port instruction decode
  input wire logic       sel_bus_ap,         // Bus port chosen
  input wire logic       sel_mgr_ap          // Manager port chosen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  swd_bscan_off_a: assert property (
    swd_mode [*3] |-> bscan == '0 && front_end_reset)
    else $error("scan live in serial mode");
  trace_follow_a: assert property (
    swd_mode && $past(swd_mode, 2)
      |-> tdo_out == $past(async_trace_out) && !tdo_oe_b)
    else $error("trace stream not on TDO");
  swd_tdi_a: assert property (
    swd_mode && $past(swd_mode) |-> tdi_released)
    else $error("TDI held");
  idle_pins_a: assert property (
    !debug_pins_claimed |-> tdi_released && front_end_reset)
    else $error("pins taken unattached");
  ap_sel_a: assert property (
    $past(rst_b, 4)
      |-> sel_bus_ap == ($past(access_port_select) == 8'h00)
       && sel_mgr_ap == ($past(access_port_select) == 8'h01))
    else $error("port select wrong");
  claim_sticky_a: assert property (
    debug_pins_claimed |=> debug_pins_claimed)
    else $error("claim lost");
  req_hold_a: assert property (
    core_reset_req && !system_manager_access_port_clear |=> core_reset_req)
    else $error("request dropped");
  req_cause_a: assert property (
    $rose(core_reset_req) |-> $past(tck_pin, 4) == 1'b0)
    else $error("request without clock low");
  bscan_decode_a: assert property (
    $stable(ir_value) && !front_end_reset && $past(front_end_reset) == 1'b0
      |-> bscan.extest == (ir_value == 4'h0)
       && bscan.sample == (ir_value == 4'h1)
       && bscan.intest == (ir_value == 4'h4)
       && bscan.clamp == (ir_value == 4'h5))
    else $error("scan decode wrong");
  dp_decode_a: assert property (
    $stable(ir_value) && !front_end_reset && $past(front_end_reset) == 1'b0
      |-> dp_instr.reserved == (ir_value[3:1] == 3'h6)
       && dp_instr.apacc == (ir_value == 4'hB)
       && dp_instr.idcode == (ir_value == 4'hE))
    else $error("port decode wrong");
endmodule : debug_port_hotplug_select_monitor

bind debug_port_hotplug_select debug_port_hotplug_select_monitor mon (.*);

/* File: debug_probe.sv */
// Model of the external debug probe on the debug clock and mode lines.
// Assumes its tasks are entered at a falling edge of clk.
`timescale 1ns/1ps
module debug_probe (
  input  wire logic clk,         // System clock, pacing only
  output logic      tck,         // Debug clock, idles high unless ext_pulse left it at lvl
  output logic      tms,         // Mode and data line
  output logic      tdi,         // Test data in
  output logic      ext_reset_b  // External reset pin
);
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    ext_reset_b = 1'b1;
  end
  // One debug clock period of 32 clk, lines change at the fall
  task tick(input logic m, input logic d);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (16) @(negedge clk);
    tck = 1'b1;
    repeat (16) @(negedge clk);
  endtask : tick
  // Unused data line keeps changing so no stale level is seen
  task highs(input int n);
    repeat (n) tick(1'b1, ~tdi);
  endtask : highs
  task pattern(input logic [15:0] p);
    for (int i = 15; i >= 0; i--) tick(p[i], ~tdi);
  endtask : pattern
  task ext_pulse(input logic lvl);
    ext_reset_b = 1'b0;
    repeat (10) @(negedge clk);
    tck = lvl;
    repeat (40) @(negedge clk);
    ext_reset_b = 1'b1;
    repeat (40) @(negedge clk);
  endtask : ext_pulse
endmodule : debug_probe

/* File: debug_port_hotplug_select_tb_top.sv */
// Self-checking bench for the debug port front end.
// Assumes the probe model drives the debug pins.
`timescale 1ns/1ps
module debug_port_hotplug_select_tb_top;
  import debug_port_pkg::*;
  logic       clk, rst_b, dp_tdo, bsr_so, async_trace_out, system_manager_access_port_clear;
  logic       tck_pin, mode_data_line, tdi_pin, ext_reset_b;
  logic       debug_pins_claimed, core_reset_req, swd_mode, tdi_released;
  logic       tdo_out, tdo_oe_b, front_end_reset, sel_bus_ap, sel_mgr_ap;
  logic [7:0] access_port_select;
  logic [3:0] ir_value;
  bscan_ctl_t bscan;
  dp_instr_t  dp_instr;
  int         n_fail = 0;
  int         n_checks = 0;

  debug_port_hotplug_select dut (.*);
  debug_probe probe (.clk, .tck(tck_pin), .tms(mode_data_line),
    .tdi(tdi_pin), .ext_reset_b);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task check(input string name, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task do_reset;
    rst_b = 1'b0;
    wait_clk(8);
    rst_b = 1'b1;
    wait_clk(8);
    check("swd_mode", swd_mode, 1'b0);
    check("claimed", debug_pins_claimed, 1'b0);
    check("tdi_released", tdi_released, 1'b1);
    check("front_end_reset", front_end_reset, 1'b1);
    check("ir_value", ir_value, 4'hE);
    check("core_reset_req", core_reset_req, 1'b0);
  endtask : do_reset

  task t_attach;
    probe.ext_pulse(1'b1);
    check("core_reset_req", core_reset_req, 1'b0);
    probe.ext_pulse(1'b0);
    check("claimed", debug_pins_claimed, 1'b0);
    check("core_reset_req", core_reset_req, 1'b1);
    wait_clk(200);
    check("core_reset_req", core_reset_req, 1'b1);
    system_manager_access_port_clear = 1'b1;
    wait_clk(1);
    system_manager_access_port_clear = 1'b0;
    wait_clk(3);
    check("core_reset_req", core_reset_req, 1'b0);
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b1, 1'b0);
    check("claimed", debug_pins_claimed, 1'b1);
    check("core_reset_req", core_reset_req, 1'b0);
    check("tdi_released", tdi_released, 1'b0);
  endtask : t_attach

  task t_ap;
    logic [7:0] v [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      access_port_select = v[i];
      wait_clk(2);
      check("sel_bus_ap", sel_bus_ap, v[i] == 8'h00);
      check("sel_mgr_ap", sel_mgr_ap, v[i] == 8'h01);
    end
  endtask : t_ap

  task load_and_check(input logic [3:0] c);
    {dp_tdo, bsr_so} = 2'b10;
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b0, 1'b0);
    probe.tick(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      probe.tick(i == 3, c[i]);
      if (i == 0) check("ir_capture", {tdo_oe_b, tdo_out}, 2'b01);
    end
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b0, 1'b0);
    check("ir_value", ir_value, c);
    check("bscan_mode", bscan[6:3], {c == 4'h0, c == 4'h1, c == 4'h4,
                                     c == 4'h5});
    check("dp_instr", dp_instr, {c == 4'h8, c == 4'hA, c == 4'hB, c == 4'hE,
                                 c == 4'hF, c[3:1] == 3'h6});
    {dp_tdo, bsr_so} = {c[0], ~c[0]};
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b0, 1'b0);
    probe.tick(1'b0, 1'b0);
    probe.tick(1'b1, 1'b0);
    check("tdo_dr", {tdo_oe_b, tdo_out},
          {1'b0, c[0] ^ (c inside {4'h0, 4'h1, 4'h4, 4'h5})});
    probe.tick(1'b1, 1'b0);
    probe.tick(1'b0, 1'b0);
    check("tdo_oe_b_idle", tdo_oe_b, 1'b1);
  endtask : load_and_check

  task t_tap;
    probe.highs(5);
    check("front_end_reset", front_end_reset, 1'b1);
    probe.tick(1'b0, 1'b0);
    check("front_end_reset", front_end_reset, 1'b0);
    for (int k = 0; k < 16; k++) load_and_check(k[3:0]);
  endtask : t_tap

  task t_swd;
    probe.highs(56);
    probe.pattern(16'h79E7);
    probe.highs(50);
    check("swd_mode", swd_mode, 1'b0);
    probe.highs(1);
    check("swd_mode", swd_mode, 1'b1);
    check("tdi_released", tdi_released, 1'b1);
    check("front_end_reset", front_end_reset, 1'b1);
    check("bscan", bscan, 8'h00);
    for (int v = 0; v < 2; v++) begin
      async_trace_out = v[0];
      wait_clk(3);
      check("trace", {tdo_oe_b, tdo_out}, {1'b0, v[0]});
    end
    probe.highs(56);
    probe.pattern(16'h79E7);
    probe.highs(56);
    check("swd_mode", swd_mode, 1'b1);
    probe.pattern(16'h3CE7);
    probe.highs(51);
    check("swd_mode", swd_mode, 1'b0);
    check("tdi_released", tdi_released, 1'b0);
    probe.highs(56);
    probe.pattern(16'h79E7);
    probe.highs(56);
    check("swd_mode", swd_mode, 1'b1);
    do_reset();
  endtask : t_swd

  initial begin
    async_trace_out = 1'b0;
    system_manager_access_port_clear = 1'b0;
    access_port_select = 8'h00;
    do_reset();
    t_attach();
    t_ap();
    t_tap();
    t_swd();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule : debug_port_hotplug_select_tb_top
